// file: rpo_pkg.sv
// Purpose: shared constants for the resolver position output ports
// Assumes: core clock 100 MHz, encoder update rate 4.096 MHz
// Notes: serial word field positions and timing figures live here
package rpo_pkg;
  localparam int unsigned ANGLE_W = 12;
  localparam int unsigned WORD_W = 16;
  // serial word layout
  localparam int unsigned SW_DATA_LSB = 4;
  localparam int unsigned SW_SEL_BIT = 3;
  localparam int unsigned SW_DOS_BIT = 2;
  localparam int unsigned SW_LOT_BIT = 1;
  localparam int unsigned SW_PAR_BIT = 0;
  // pin positions of the shared data lines in serial mode
  localparam int unsigned SO_LINE = 11;
  localparam int unsigned SCLK_LINE = 10;
  // encoder update tick, fractional divide of the core clock
  localparam int unsigned CORE_CLK_KHZ = 100000;
  localparam int unsigned ENC_CLK_KHZ = 4096;
  localparam int unsigned TICK_ACC_W = 17;
  localparam logic [TICK_ACC_W-1:0] TICK_INC = TICK_ACC_W'(ENC_CLK_KHZ);
  localparam logic [TICK_ACC_W-1:0] TICK_MOD = TICK_ACC_W'(CORE_CLK_KHZ);
  // quadrature phase states, A leads B while counting up
  localparam logic [1:0] QUAD_PH0 = 2'h0;
  localparam logic [1:0] QUAD_PH1 = 2'h1;
  localparam logic [1:0] QUAD_PH2 = 2'h2;
  localparam logic [1:0] QUAD_PH3 = 2'h3;
  localparam logic [ANGLE_W-1:0] ANGLE_ZERO = 12'h000;
  localparam logic [ANGLE_W-1:0] ANGLE_ONE = 12'h001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
endpackage

// file: rpo_edge.sv
// Purpose: edge detector for synchronous strobe inputs
// Assumes: inputs already synchronous to CLK
// Notes: one flop of history per bit, pulses are combinational
`timescale 1ns/100ps
module rpo_edge #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= IDLE;
    end else begin
      prev_r <= din;
    end
  end

  assign rise = din & ~prev_r;
  assign fall = ~din & prev_r;
endmodule

// file: rpo_ports.sv
// What this block does
// - reads are served only while chip select is low.
// - select high reads position, low reads velocity, into the output register.
// - parallel mode drives the twelve lines only while chip select and strobe are low.
// - strobe falling edge loads the selected value into buffer or shift register.
// - strobe high releases the parallel lines to high impedance.
// - serial enable low picks serial port, high picks parallel port.
// - serial mode: line eleven is data out, line ten is clock in, rest undriven.
// - sixteen bit serial word, sent most significant bit first.
// - serial bits fifteen to four carry the chosen twelve bit value.
// - position unsigned binary, velocity two's complement, passed unchanged.
// - serial bit three echoes the select: one position, zero velocity.
// - serial bit two is degradation flag, bit one is tracking loss flag.
// - serial bit zero makes the whole word hold an odd count of ones.
// - first bit valid before first falling clock, later bits shift on rising.
// - after sixteen bits, further clocks with strobe low give zeros.
// - sample falling edge latches both integrators; host waits before reading.
// - encoder gives 1024 quadrature pulses per turn, A leads B when increasing.
// - direction output high for increasing angle, may toggle within one step.
// - north marker high as angle passes zero, one quarter of an A cycle.
// - encoder steps at the 4.096 MHz rate, four steps per pulse.
//
// Purpose: output side of a resolver converter: ports and encoder emulation
// Assumes: all pins synchronous to CLK; SCLK sampled, so period >= 4 CLK
// Notes: a two-way line is split into input, output and output enable
`timescale 1ns/100ps
module rpo_ports
  import rpo_pkg::*;
#(
  parameter int unsigned DATA_W = ANGLE_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [DATA_W-1:0] POS_INTEG,
  input wire logic [DATA_W-1:0] VEL_INTEG,
  input wire logic SAMPLE_N,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic POSITION_VELOCITY_SELECT,
  input wire logic SERIAL_OUTPUT_ENABLE_N,
  input wire logic SIGNAL_DEGRADATION_FLAG,
  input wire logic TRACKING_LOSS_FLAG,
  input wire logic [DATA_W-1:0] DATA_LINE_IN,
  output logic [DATA_W-1:0] DATA_LINE_OUT,
  output logic [DATA_W-1:0] DATA_LINE_OE,
  output logic ENC_A,
  output logic ENC_B,
  output logic ROTATION_SENSE,
  output logic NORTH_MARKER
);
  generate
    if (DATA_W != ANGLE_W) begin : g_bad_width
      $error("rpo_ports: DATA_W must equal the 12 bit angle width");
    end
  endgenerate

  logic [DATA_W-1:0] pos_r;
  logic [DATA_W-1:0] vel_r;
  logic [DATA_W-1:0] outbuf_r;
  logic [WORD_W-1:0] shift_r;
  logic [DATA_W-1:0] sel_value;
  logic [WORD_W-1:0] word_nxt;
  logic [2:0] fall_v;
  logic [2:0] rise_v;
  logic sample_fall;
  logic rd_fall;
  logic sclk_rise;
  logic rd_active;
  logic serial_mode;
  logic load_now;

  // sample strobe, read strobe and serial clock share one detector
  rpo_edge #(.W(3), .IDLE(3'h7)) u_edge (
    .clk(CLK),
    .rst(RST),
    .din({DATA_LINE_IN[SCLK_LINE], READ_STROBE_N, SAMPLE_N}),
    .rise(rise_v),
    .fall(fall_v)
  );

  assign sample_fall = fall_v[0];
  assign rd_fall = fall_v[1];
  assign sclk_rise = rise_v[2];
  assign serial_mode = ~SERIAL_OUTPUT_ENABLE_N;
  assign rd_active = ~CHIP_SELECT_N & ~READ_STROBE_N;
  assign load_now = rd_fall & ~CHIP_SELECT_N;

  // conversion keeps running; only the snapshot waits for the edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      pos_r <= ANGLE_ZERO;
      vel_r <= ANGLE_ZERO;
    end else if (sample_fall) begin
      pos_r <= POS_INTEG;
      vel_r <= VEL_INTEG;
    end
  end

  // both formats pass through untouched, the host interprets them
  assign sel_value = POSITION_VELOCITY_SELECT ? pos_r : vel_r;

  always_comb begin
    word_nxt = WORD_ZERO;
    word_nxt[WORD_W-1:SW_DATA_LSB] = sel_value;
    word_nxt[SW_SEL_BIT] = POSITION_VELOCITY_SELECT;
    word_nxt[SW_DOS_BIT] = SIGNAL_DEGRADATION_FLAG;
    word_nxt[SW_LOT_BIT] = TRACKING_LOSS_FLAG;
    word_nxt[SW_PAR_BIT] = ~(^word_nxt[WORD_W-1:SW_LOT_BIT]);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      outbuf_r <= ANGLE_ZERO;
    end else if (load_now & ~serial_mode) begin
      outbuf_r <= sel_value;
    end
  end

  // zeros fill from the bottom, so a long strobe clocks out zeros
  always_ff @(posedge CLK) begin
    if (RST) begin
      shift_r <= WORD_ZERO;
    end else if (load_now & serial_mode) begin
      shift_r <= word_nxt;
    end else if (sclk_rise & rd_active) begin
      shift_r <= {shift_r[WORD_W-2:0], 1'b0};
    end
  end

  // a rising clock in the load cycle is ignored: the host strobes in clock high
  // output enable follows the strobes one cycle late
  always_ff @(posedge CLK) begin
    if (RST) begin
      DATA_LINE_OE <= '0;
    end else if (serial_mode) begin
      DATA_LINE_OE <= '0;
      DATA_LINE_OE[SO_LINE] <= rd_active;
    end else begin
      DATA_LINE_OE <= {DATA_W{rd_active}};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      DATA_LINE_OUT <= '0;
    end else if (serial_mode) begin
      DATA_LINE_OUT <= '0;
      DATA_LINE_OUT[SO_LINE] <= load_now ? word_nxt[WORD_W-1] : shift_r[WORD_W-1];
    end else begin
      DATA_LINE_OUT <= load_now ? sel_value : outbuf_r;
    end
  end

  // encoder emulation: a follower counter chases the live angle
  logic [TICK_ACC_W-1:0] tick_acc_r;
  logic tick_r;
  logic [DATA_W-1:0] enc_cnt_r;
  logic [DATA_W-1:0] enc_diff;
  logic enc_dir_r;

  always_ff @(posedge CLK) begin
    if (RST) begin
      tick_acc_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_acc_r + TICK_INC >= TICK_MOD) begin
      tick_acc_r <= tick_acc_r + TICK_INC - TICK_MOD;
      tick_r <= 1'b1;
    end else begin
      tick_acc_r <= tick_acc_r + TICK_INC;
      tick_r <= 1'b0;
    end
  end

  assign enc_diff = POS_INTEG - enc_cnt_r;

  // one count per tick caps speed at the documented switching rate
  always_ff @(posedge CLK) begin
    if (RST) begin
      enc_cnt_r <= ANGLE_ZERO;
      enc_dir_r <= 1'b1;
    end else if (tick_r && enc_diff != ANGLE_ZERO) begin
      enc_dir_r <= ~enc_diff[DATA_W-1];
      enc_cnt_r <= enc_diff[DATA_W-1] ? enc_cnt_r - ANGLE_ONE : enc_cnt_r + ANGLE_ONE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ENC_A <= 1'b0;
      ENC_B <= 1'b0;
      ROTATION_SENSE <= 1'b1;
      NORTH_MARKER <= 1'b0;
    end else begin
      // four counts per A/B period gives 1024 pulses from 4096 counts
      unique case (enc_cnt_r[1:0])
        QUAD_PH0: begin
          ENC_A <= 1'b0;
          ENC_B <= 1'b0;
        end
        QUAD_PH1: begin
          ENC_A <= 1'b1;
          ENC_B <= 1'b0;
        end
        QUAD_PH2: begin
          ENC_A <= 1'b1;
          ENC_B <= 1'b1;
        end
        QUAD_PH3: begin
          ENC_A <= 1'b0;
          ENC_B <= 1'b1;
        end
      endcase
      ROTATION_SENSE <= enc_dir_r;
      NORTH_MARKER <= (enc_cnt_r == ANGLE_ZERO);
    end
  end

  // checks
  sequence s_serial_load;
    load_now && serial_mode;
  endsequence

  sequence s_enc_step;
    tick_r && (enc_diff != ANGLE_ZERO);
  endsequence

  sequence s_enc_up;
    tick_r && (enc_diff != ANGLE_ZERO) && !enc_diff[DATA_W-1];
  endsequence

  chk_oe_needs_cs: assert property (@(posedge CLK) disable iff (RST)
    (DATA_LINE_OE != '0) |-> $past(CHIP_SELECT_N) == 1'b0)
    else $error("data lines driven without chip select");

  chk_parallel_drive: assert property (@(posedge CLK) disable iff (RST)
    (rd_active && !serial_mode) |=> (DATA_LINE_OE == {DATA_W{1'b1}}))
    else $error("parallel lines not driven during read");

  chk_release_hiz: assert property (@(posedge CLK) disable iff (RST)
    READ_STROBE_N |=> (DATA_LINE_OE == '0))
    else $error("lines still driven after strobe high");

  chk_serial_lower_hiz: assert property (@(posedge CLK) disable iff (RST)
    serial_mode |=> (DATA_LINE_OE[SO_LINE-1:0] == '0))
    else $error("lower lines driven in serial mode");

  chk_word_value: assert property (@(posedge CLK) disable iff (RST)
    s_serial_load |=> (shift_r[WORD_W-1:SW_DATA_LSB] == $past(sel_value))
      && (shift_r[SW_SEL_BIT] == $past(POSITION_VELOCITY_SELECT)))
    else $error("serial word data or select echo wrong");

  chk_odd_parity: assert property (@(posedge CLK) disable iff (RST)
    s_serial_load |=> (^shift_r) == 1'b1)
    else $error("serial word parity not odd");

  chk_shift_step: assert property (@(posedge CLK) disable iff (RST)
    (sclk_rise && rd_active && !load_now) |=> shift_r == {$past(shift_r[WORD_W-2:0]), 1'b0})
    else $error("serial shift step wrong");

  chk_par_load: assert property (@(posedge CLK) disable iff (RST)
    (load_now && !serial_mode) |=> (outbuf_r == $past(sel_value))
      ##1 (READ_STROBE_N || DATA_LINE_OUT == outbuf_r))
    else $error("parallel buffer not loaded on strobe edge");

  chk_sample_latch: assert property (@(posedge CLK) disable iff (RST)
    sample_fall |=> (pos_r == $past(POS_INTEG)) && (vel_r == $past(VEL_INTEG)))
    else $error("sample edge did not latch integrators");

  chk_enc_step: assert property (@(posedge CLK) disable iff (RST)
    s_enc_step |=> (enc_cnt_r != $past(enc_cnt_r)) ##1 !tick_r)
    else $error("encoder count did not step on tick");

  chk_north_zero: assert property (@(posedge CLK) disable iff (RST)
    NORTH_MARKER |-> ($past(enc_cnt_r) == ANGLE_ZERO) && !ENC_A && !ENC_B)
    else $error("north marker outside zero count");

  chk_select_route: assert property (@(posedge CLK) disable iff (RST)
    (load_now && !serial_mode) |=> outbuf_r == ($past(POSITION_VELOCITY_SELECT) ? $past(pos_r) : $past(vel_r)))
    else $error("parallel buffer took the wrong register");

  chk_serial_no_par: assert property (@(posedge CLK) disable iff (RST)
    serial_mode |=> $stable(outbuf_r))
    else $error("parallel buffer changed in serial mode");

  chk_refused_read: assert property (@(posedge CLK) disable iff (RST)
    (rd_fall && CHIP_SELECT_N) |=> $stable(outbuf_r) && $stable(shift_r))
    else $error("read without chip select loaded data");

  chk_flag_bits: assert property (@(posedge CLK) disable iff (RST)
    s_serial_load |=> (shift_r[SW_DOS_BIT] == $past(SIGNAL_DEGRADATION_FLAG))
      && (shift_r[SW_LOT_BIT] == $past(TRACKING_LOSS_FLAG)))
    else $error("serial status bits wrong");

  chk_msb_first: assert property (@(posedge CLK) disable iff (RST)
    s_serial_load |=> (DATA_LINE_OUT[SO_LINE] == shift_r[WORD_W-1]) && DATA_LINE_OE[SO_LINE])
    else $error("first serial bit not the word msb");

  chk_so_follows: assert property (@(posedge CLK) disable iff (RST)
    (serial_mode && !load_now) |=> DATA_LINE_OUT[SO_LINE] == $past(shift_r[WORD_W-1]))
    else $error("serial output not the shift register msb");

  chk_quad_phase: assert property (@(posedge CLK) disable iff (RST)
    ((ENC_A ^ ENC_B) == $past(enc_cnt_r[0])) && (ENC_B == $past(enc_cnt_r[1])))
    else $error("quadrature outputs do not match the count");

  chk_dir_up: assert property (@(posedge CLK) disable iff (RST)
    s_enc_up |=> (enc_cnt_r == $past(enc_cnt_r) + ANGLE_ONE) ##1 ROTATION_SENSE)
    else $error("upward step without rising direction");
endmodule

// file: rpo_host.sv
// Purpose: host model driving the read strobes and the serial clock
// Assumes: host acts on falling CLK edges
// Notes: serial clock idles high and stands still between frames
`timescale 1ns/100ps
module rpo_host (
  input wire logic clk,
  input wire logic so,
  input wire logic [11:0] dl_out,
  input wire logic [11:0] dl_oe,
  output logic sclk,
  output logic cs_n,
  output logic rd_n
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
  // cs_low=0 tries a read with the device not selected
  task automatic par_read(input logic cs_low, output logic [11:0] d, output logic [11:0] oe_on,
                          output logic [11:0] oe_off);
    @(negedge clk);
    cs_n = ~cs_low;
    rd_n = 1'b0;
    repeat (2) @(negedge clk);
    d = dl_out;
    oe_on = dl_oe;
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (2) @(negedge clk);
    oe_off = dl_oe;
  endtask
  // two clocks past the word, so trailing zeros are seen too
  task automatic ser_read(output logic [17:0] w, output logic [11:0] oe_acc);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    oe_acc = 12'h000;
    for (int i = 17; i >= 0; i--) begin
      repeat (3) @(negedge clk);
      sclk = 1'b0;
      w[i] = so;
      oe_acc = oe_acc | dl_oe;
      repeat (2) @(negedge clk);
      sclk = 1'b1;
    end
    @(negedge clk);
    rd_n = 1'b1;
    cs_n = 1'b1;
  endtask
endmodule

// file: rpo_ports_tb_top.sv
// Purpose: self-checking bench for the resolver output ports
// Assumes: inputs change on falling CLK edges
// Notes: undriven lines read back inverted, never as a stale value
`timescale 1ns/100ps
module rpo_ports_tb_top;
  // {serial_n, select, degradation, loss, position, velocity}
  localparam logic [27:0] ROWS [6] = '{28'hCABC123, 28'h8ABC123, 28'h45A5F00,
                                       28'h3000800, 28'h6FFF7FF, 28'h1001FFF};
  logic CLK, RST, sample_n, sel, soe_n, signal_degradation_flag, tracking_loss_flag, enc_a, enc_b, dir, nm, sclk, cs_n, rd_n;
  logic [11:0] pos, vel, lvl, lines_in, out, oe, d, on, off, v;
  logic [17:0] w;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  assign lvl = out ^ ~oe;
  assign lines_in = {lvl[11], soe_n ? lvl[10] : sclk, lvl[9:0]};
  rpo_ports i_rpo_ports (.CLK(CLK), .RST(RST), .POS_INTEG(pos), .VEL_INTEG(vel), .SAMPLE_N(sample_n),
    .CHIP_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .POSITION_VELOCITY_SELECT(sel),
    .SERIAL_OUTPUT_ENABLE_N(soe_n), .SIGNAL_DEGRADATION_FLAG(signal_degradation_flag), .TRACKING_LOSS_FLAG(tracking_loss_flag),
    .DATA_LINE_IN(lines_in), .DATA_LINE_OUT(out), .DATA_LINE_OE(oe), .ENC_A(enc_a), .ENC_B(enc_b),
    .ROTATION_SENSE(dir), .NORTH_MARKER(nm));
  rpo_host i_rpo_host (.clk(CLK), .so(lvl[11]), .dl_out(out), .dl_oe(oe), .sclk(sclk), .cs_n(cs_n),
    .rd_n(rd_n));
  always #5 CLK = ~CLK;
  task automatic results();
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // live inputs move away after the latch, so a stale copy shows
  task automatic sample(input logic [11:0] p, input logic [11:0] q);
    pos = p;
    vel = q;
    @(negedge CLK);
    sample_n = 1'b0;
    repeat (3) @(negedge CLK);
    sample_n = 1'b1;
    pos = ~p;
    vel = ~q;
    repeat (6) @(negedge CLK);
  endtask
  task automatic enc_step(input logic [11:0] p, input logic [3:0] exp);
    pos = p;
    repeat (80) @(negedge CLK);
    chk({enc_a, enc_b, dir, nm}, exp);
  endtask
  initial begin
    CLK = 1'b0;
    RST = 1'b1;
    pos = 12'h000;
    vel = 12'h000;
    {sample_n, sel, soe_n, signal_degradation_flag, tracking_loss_flag} = 5'h1C;
    repeat (8) @(negedge CLK);
    RST = 1'b0;
    repeat (2) @(negedge CLK);
    chk(oe, 12'h000);
    chk({enc_a, enc_b, dir, nm}, 4'h3);
    enc_step(12'h001, 4'hA);
    enc_step(12'h002, 4'hE);
    enc_step(12'h000, 4'h1);
    foreach (ROWS[k]) begin
      {soe_n, sel, signal_degradation_flag, tracking_loss_flag} = ROWS[k][27:24];
      sample(ROWS[k][23:12], ROWS[k][11:0]);
      v = sel ? ROWS[k][23:12] : ROWS[k][11:0];
      if (soe_n) begin
        i_rpo_host.par_read(1'b1, d, on, off);
        chk(d, v);
        chk(on, 12'hFFF);
        chk(off, 12'h000);
      end else begin
        i_rpo_host.ser_read(w, on);
        chk(w, {v, sel, signal_degradation_flag, tracking_loss_flag, ~^{v, sel, signal_degradation_flag, tracking_loss_flag}, 2'b00});
        chk(on, 12'h800);
        repeat (2) @(negedge CLK);
        chk(oe, 12'h000);
      end
    end
    // strobe without select must leave the lines floating
    soe_n = 1'b1;
    i_rpo_host.par_read(1'b0, d, on, off);
    chk(on, 12'h000);
    // mid-run reset returns snapshot, encoder and lines to idle
    sel = 1'b1;
    RST = 1'b1;
    repeat (2) @(negedge CLK);
    RST = 1'b0;
    chk({enc_a, enc_b, dir, nm, oe}, 16'h2000);
    repeat (2) @(negedge CLK);
    chk({enc_a, enc_b, dir, nm}, 4'h3);
    i_rpo_host.par_read(1'b1, d, on, off);
    chk(d, 12'h000);
    results();
  end
endmodule
